// ### scfg_pkg.sv
package scfg_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_OOR_THR_LOW = 8'h32;
	localparam logic [7:0] ADDR_OOR_THR_MID = 8'h33;
	localparam logic [7:0] ADDR_OOR_RANGE = 8'h34;
	localparam logic [7:0] ADDR_OOR_CTRL = 8'h35;
	localparam logic [7:0] ADDR_OSR_SET = 8'h36;
	localparam logic [7:0] ADDR_RATE_PWR = 8'h37;
	localparam logic [7:0] ADDR_OSR_EFF = 8'h38;
	localparam logic [7:0] ADDR_INT_STAT = 8'h27;
	localparam logic [7:0] ADDR_CMD = 8'h7E;
	localparam logic [7:0] ADDR_PAGE = 8'h7F;

	// ****************************************
	// Reset values and writable masks
	// ****************************************
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_RATE_PWR = 8'h70;
	localparam logic [7:0] MASK_OOR_CTRL = 8'hC1;
	localparam logic [7:0] MASK_OSR_SET = 8'h7F;
	localparam logic [7:0] MASK_PAGE = 8'h90;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int POS_OSR_T = 0;
	localparam int POS_OSR_P = 3;
	localparam int POS_PRESS_EN = 6;
	localparam int POS_CNT_LIM = 6;
	localparam int POS_PWR = 0;
	localparam int POS_RATE = 2;
	localparam int POS_DEEP_DIS = 7;
	localparam int POS_VALID = 7;
	localparam int POS_OOR_INT = 3;
	localparam int POS_PAGE_SEL = 4;
	localparam int POS_PAGE_EN = 7;

	// ****************************************
	// Commands
	// ****************************************
	localparam logic [7:0] CMD_SOFT_RESET = 8'hB6;
	localparam logic [7:0] CMD_UNLOCK_OPEN = 8'h5D;
	localparam logic [7:0] CMD_NVM_READ = 8'hA5;
	localparam logic [7:0] CMD_NVM_PROG = 8'hA0;

	// ****************************************
	// Modes, states, timing
	// ****************************************
	typedef enum logic [1:0] {
		PWR_STANDBY = 2'b00,
		PWR_NORMAL = 2'b01,
		PWR_FORCED = 2'b10,
		PWR_NONSTOP = 2'b11
	} scfg_pwr_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_OPENED = 2'b01
	} scfg_seq_t;

	localparam logic [2:0] OSR_DEFAULT = 3'h0;
	// Base conversion cycles per oversample unit (pressure+temp)
	localparam int CONV_BASE_CYC = 4;
	localparam logic [11:0] CONV_CYC_UNIT = 12'h004;
	// Fastest rate period budget scaled per rate code: 240 Hz at 40 MHz
	localparam int CLK_HZ = 40000000;
	localparam int RATE0_HZ = 240;
	localparam int RATE0_CYC = CLK_HZ / RATE0_HZ;
endpackage : scfg_pkg

// ### scfg_regs.sv
// Contract
// - 17-bit threshold across three registers
// - Full-byte range field, resets zero
// - Count limit field at bit six
// - Temperature oversampling code n gives 2^n
// - Pressure oversampling field at bit three
// - Pressure enable chooses pressure or temperature-only
// - Invalid rate/oversampling falls back to defaults
// - Validity flag recomputed on config change
// - Power mode decode standby/normal/forced/nonstop
// - Mode readback is actual; forced clears
// - Five-bit rate field, reset selects 1 Hz
// - Deep standby disable bit seven
// - Effective oversampling codes readable
// - Command register always reads zero
// - 0xB6 soft reset, no I2C acknowledge
// - 0x5D then 0xA5 unlocks NVM read
// - 0x5D then 0xA0 unlocks NVM program
// - Other command aborts partial unlock sequence
// - Paging enable bit seven, page bit four
// - Out-of-range event in status bit three
`timescale 1ns/1ps
`default_nettype none
module scfg_regs
	import scfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic wr_is_i2c,
	input wire logic conv_busy,
	input wire logic conv_done,
	input wire logic [16:0] press_sample,
	output logic [7:0] reg_rdata,
	output logic wr_nack,
	output logic [1:0] pwr_mode_act,
	output logic meas_press_en,
	output logic [2:0] osr_t_use,
	output logic [2:0] osr_p_use,
	output logic [4:0] rate_sel,
	output logic deep_stby_off,
	output logic nvm_read_unlock,
	output logic nvm_prog_unlock,
	output logic paging_on,
	output logic page_sel,
	output logic oor_event
);
	import scfg_pkg::*;

	// ****************************************
	// Storage
	// ****************************************
	logic [7:0] thr_low_r, thr_mid_r, range_r, oor_ctrl_r, osr_r, rate_pwr_r, page_r;
	logic [7:0] rdata_r;
	logic [2:0] osr_t_eff_r, osr_p_eff_r;
	logic valid_r, nack_r, rd_unl_r, pg_unl_r, oor_flag_r, oor_pulse_r;
	logic [3:0] oor_cnt_r;
	scfg_pwr_t mode_r;
	scfg_seq_t seq_r;

	// ****************************************
	// Decode
	// ****************************************
	// Address strobes
	wire logic is_cmd = reg_wr && reg_addr == ADDR_CMD;
	wire logic soft_rst = is_cmd && reg_wdata == CMD_SOFT_RESET;
	wire logic wr_thr_low = reg_wr && reg_addr == ADDR_OOR_THR_LOW;
	wire logic wr_thr_mid = reg_wr && reg_addr == ADDR_OOR_THR_MID;
	wire logic wr_range = reg_wr && reg_addr == ADDR_OOR_RANGE;
	wire logic wr_oor_ctrl = reg_wr && reg_addr == ADDR_OOR_CTRL;
	wire logic wr_osr = reg_wr && reg_addr == ADDR_OSR_SET;
	wire logic wr_rate = reg_wr && reg_addr == ADDR_RATE_PWR;
	wire logic wr_page = reg_wr && reg_addr == ADDR_PAGE;
	wire logic rd_int = reg_rd && reg_addr == ADDR_INT_STAT;

	// Field views
	wire logic [16:0] thr = {oor_ctrl_r[0], thr_mid_r, thr_low_r};
	wire logic [1:0] cnt_code = oor_ctrl_r[POS_CNT_LIM +: 2];
	wire logic [3:0] cnt_lim = {cnt_code == 2'h3, cnt_code >= 2'h2, cnt_code >= 2'h1, 1'b1};
	wire logic [2:0] osr_t_cfg = osr_r[POS_OSR_T +: 3];
	wire logic [2:0] osr_p_cfg = osr_r[POS_OSR_P +: 3];
	wire logic [4:0] rate_cfg = rate_pwr_r[POS_RATE +: 5];
	wire logic [1:0] pwr_req = rate_pwr_r[POS_PWR +: 2];

	// Rate validity: conversion time 2^osr units must fit the rate period
	// Widths hold 128 + 128 and 8 << 7 without wrapping
	wire logic [8:0] osr_sum = 9'(9'h001 << osr_t_cfg) + (osr_r[POS_PRESS_EN] ? 9'(9'h001 << osr_p_cfg) : 9'h000);
	wire logic [10:0] rate_budget = 11'(11'h008 << rate_cfg[4:2]);
	wire logic cfg_valid = (pwr_req != PWR_NORMAL) || ({2'b00, osr_sum} <= rate_budget);

	// Out-of-range window: |sample - threshold| > range
	wire logic [17:0] diff = {1'b0, press_sample} - {1'b0, thr};
	wire logic [16:0] mag = diff[17] ? 17'(-diff) : diff[16:0];
	wire logic out_rng = mag > {9'h000, range_r};

	// ****************************************
	// Configuration registers
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst || 1'b0) begin
			thr_low_r <= RST_ZERO;
			thr_mid_r <= RST_ZERO;
			range_r <= RST_ZERO;
			oor_ctrl_r <= RST_ZERO;
			osr_r <= RST_ZERO;
			rate_pwr_r <= RST_RATE_PWR;
			page_r <= RST_ZERO;
		end else if (soft_rst) begin
			thr_low_r <= RST_ZERO;
			thr_mid_r <= RST_ZERO;
			range_r <= RST_ZERO;
			oor_ctrl_r <= RST_ZERO;
			osr_r <= RST_ZERO;
			rate_pwr_r <= RST_RATE_PWR;
			page_r <= RST_ZERO;
		end else begin
			if (wr_thr_low) thr_low_r <= reg_wdata;
			if (wr_thr_mid) thr_mid_r <= reg_wdata;
			if (wr_range) range_r <= reg_wdata;
			// Count limit held while converting
			if (wr_oor_ctrl) begin
				oor_ctrl_r <= conv_busy ? {oor_ctrl_r[7:6], 5'h00, reg_wdata[0]} : (reg_wdata & MASK_OOR_CTRL);
			end
			if (wr_osr) osr_r <= reg_wdata & MASK_OSR_SET;
			if (wr_rate) begin
				rate_pwr_r <= {conv_busy ? rate_pwr_r[POS_DEEP_DIS] : reg_wdata[POS_DEEP_DIS], reg_wdata[6:0]};
			end else if (mode_r == PWR_FORCED && conv_done) begin
				rate_pwr_r[1:0] <= PWR_STANDBY;
			end
			if (wr_page) page_r <= reg_wdata & MASK_PAGE;
		end
	end

	// ****************************************
	// Actual mode, effective oversampling
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_r <= PWR_STANDBY;
			valid_r <= 1'b0;
			osr_t_eff_r <= OSR_DEFAULT;
			osr_p_eff_r <= OSR_DEFAULT;
		end else begin
			mode_r <= soft_rst ? PWR_STANDBY : scfg_pwr_t'(pwr_req);
			valid_r <= cfg_valid;
			osr_t_eff_r <= cfg_valid ? osr_t_cfg : OSR_DEFAULT;
			osr_p_eff_r <= cfg_valid ? osr_p_cfg : OSR_DEFAULT;
		end
	end

	// ****************************************
	// Unlock sequence
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			seq_r <= SEQ_IDLE;
			rd_unl_r <= 1'b0;
			pg_unl_r <= 1'b0;
		end else if (soft_rst) begin
			seq_r <= SEQ_IDLE;
			rd_unl_r <= 1'b0;
			pg_unl_r <= 1'b0;
		end else if (is_cmd) begin
			case (seq_r)
				SEQ_IDLE: begin
					seq_r <= (reg_wdata == CMD_UNLOCK_OPEN) ? SEQ_OPENED : SEQ_IDLE;
				end
				SEQ_OPENED: begin
					seq_r <= SEQ_IDLE;
					if (reg_wdata == CMD_NVM_READ) rd_unl_r <= 1'b1;
					if (reg_wdata == CMD_NVM_PROG) pg_unl_r <= 1'b1;
				end
				default: begin
					seq_r <= SEQ_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Out-of-range counter and status flag
	// ****************************************
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			oor_cnt_r <= 4'h0;
			oor_flag_r <= 1'b0;
			oor_pulse_r <= 1'b0;
		end else if (soft_rst) begin
			// Run of samples restarts with the defaults
			oor_cnt_r <= 4'h0;
			oor_pulse_r <= 1'b0;
		end else begin
			oor_pulse_r <= 1'b0;
			// Reaching the limit fires and restarts the run; a lowered limit fires on the next out-of-range sample
			if (conv_done && osr_r[POS_PRESS_EN]) begin
				oor_cnt_r <= (out_rng && (oor_cnt_r + 4'h1 < cnt_lim)) ? oor_cnt_r + 4'h1 : 4'h0;
				oor_pulse_r <= out_rng && (oor_cnt_r + 4'h1 >= cnt_lim);
			end
			// Set wins over clear-on-read
			if (oor_pulse_r) oor_flag_r <= 1'b1;
			else if (rd_int) oor_flag_r <= 1'b0;
		end
	end

	// ****************************************
	// Read mux and nack
	// ****************************************
	wire logic [7:0] rd_mux =
		(reg_addr == ADDR_OOR_THR_LOW) ? thr_low_r :
		(reg_addr == ADDR_OOR_THR_MID) ? thr_mid_r :
		(reg_addr == ADDR_OOR_RANGE) ? range_r :
		(reg_addr == ADDR_OOR_CTRL) ? oor_ctrl_r :
		(reg_addr == ADDR_OSR_SET) ? osr_r :
		(reg_addr == ADDR_RATE_PWR) ? {rate_pwr_r[7:2], mode_r} :
		(reg_addr == ADDR_OSR_EFF) ? {valid_r, 1'b0, osr_p_eff_r, osr_t_eff_r} :
		(reg_addr == ADDR_INT_STAT) ? {4'h0, oor_flag_r, 3'h0} :
		(reg_addr == ADDR_PAGE) ? page_r :
		RST_ZERO;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_r <= RST_ZERO;
			nack_r <= 1'b0;
		end else begin
			rdata_r <= reg_rd ? rd_mux : RST_ZERO;
			nack_r <= soft_rst && wr_is_i2c;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata = rdata_r;
	assign wr_nack = nack_r;
	assign pwr_mode_act = mode_r;
	assign meas_press_en = osr_r[POS_PRESS_EN];
	assign osr_t_use = osr_t_eff_r;
	assign osr_p_use = osr_p_eff_r;
	assign rate_sel = rate_pwr_r[POS_RATE +: 5];
	assign deep_stby_off = rate_pwr_r[POS_DEEP_DIS];
	assign nvm_read_unlock = rd_unl_r;
	assign nvm_prog_unlock = pg_unl_r;
	assign paging_on = page_r[POS_PAGE_EN];
	assign page_sel = page_r[POS_PAGE_SEL];
	assign oor_event = oor_flag_r;
endmodule : scfg_regs
`default_nettype wire

// ### scfg_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module scfg_regs_chk
	import scfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic wr_is_i2c,
	input wire logic conv_busy,
	input wire logic conv_done,
	input wire logic [7:0] reg_rdata,
	input wire logic wr_nack,
	input wire logic [1:0] pwr_mode_act,
	input wire logic meas_press_en,
	input wire logic [4:0] rate_sel,
	input wire logic deep_stby_off,
	input wire logic nvm_read_unlock,
	input wire logic nvm_prog_unlock,
	input wire logic paging_on,
	input wire logic page_sel
);
	// ****************************************
	// Decodes and properties
	// ****************************************
	logic cw;
	logic rw;
	// Command and rate register writes
	assign cw = reg_wr && reg_addr == ADDR_CMD;
	assign rw = reg_wr && reg_addr == ADDR_RATE_PWR;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	a_cmd_reads_zero: assert property (reg_rd && reg_addr == ADDR_CMD |=> reg_rdata == 8'h00)
		else $error("command register read not zero");
	a_nack_on_reset: assert property (cw && reg_wdata == CMD_SOFT_RESET && wr_is_i2c |=> wr_nack)
		else $error("no refusal after soft reset");
	a_nack_cause: assert property (wr_nack |-> $past(cw && wr_is_i2c && reg_wdata == CMD_SOFT_RESET))
		else $error("refusal without soft reset");
	a_soft_rst_dflt: assert property (cw && reg_wdata == CMD_SOFT_RESET |=> rate_sel == 5'h1C && !nvm_read_unlock)
		else $error("soft reset left settings");
	a_rd_unlock_why: assert property ($rose(nvm_read_unlock) |-> $past(cw && reg_wdata == CMD_NVM_READ))
		else $error("read unlock without closing code");
	a_pg_unlock_why: assert property ($rose(nvm_prog_unlock) |-> $past(cw && reg_wdata == CMD_NVM_PROG))
		else $error("program unlock without closing code");
	a_rate_write: assert property (rw && !conv_busy |=> rate_sel == $past(reg_wdata[6:2]))
		else $error("rate field not taken");
	a_press_en_wr: assert property (reg_wr && reg_addr == ADDR_OSR_SET |=> meas_press_en == $past(reg_wdata[6]))
		else $error("pressure enable not taken");
	a_page_write: assert property (reg_wr && reg_addr == ADDR_PAGE |=> {paging_on, page_sel} == {$past(reg_wdata[7]),
		$past(reg_wdata[4])})
		else $error("paging bits not taken");
	a_deep_locked: assert property (rw && conv_busy |=> $stable(deep_stby_off))
		else $error("deep standby bit changed while busy");
	a_forced_ends: assert property (pwr_mode_act == PWR_FORCED && conv_done && !reg_wr |=> ##[0:1]
		pwr_mode_act == PWR_STANDBY)
		else $error("forced mode did not end");
	// Main scenarios
	c_soft_rst: cover property (cw && reg_wdata == CMD_SOFT_RESET);
	c_prog_unlock: cover property ($rose(nvm_prog_unlock));
	c_forced_end: cover property ($fell(pwr_mode_act[1]));
endmodule : scfg_regs_chk
bind scfg_regs scfg_regs_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .wr_is_i2c(wr_is_i2c), .conv_busy(conv_busy),
	.conv_done(conv_done), .reg_rdata(reg_rdata), .wr_nack(wr_nack), .pwr_mode_act(pwr_mode_act),
	.meas_press_en(meas_press_en), .rate_sel(rate_sel), .deep_stby_off(deep_stby_off),
	.nvm_read_unlock(nvm_read_unlock), .nvm_prog_unlock(nvm_prog_unlock), .paging_on(paging_on),
	.page_sel(page_sel));
`default_nettype wire

// ### scfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module scfg_host (
	input wire logic clk_sys,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic wr_is_i2c
);
	// Idle bus at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		wr_is_i2c = 1'b0;
	end
	// Byte write, held over one sampling edge, then address scrambled
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic i);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		wr_is_i2c = i;
		@(negedge clk_sys);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
		wr_is_i2c = 1'b0;
	endtask : wr
	// Byte read, data taken one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		d = reg_rdata;
		reg_rd = 1'b0;
		reg_addr = ~a;
	endtask : rd
endmodule : scfg_host
`default_nettype wire

// ### test_sensor_config_command_regs.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; \
	if ((g) !== (e)) begin bad_count++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_sensor_config_command_regs
	import scfg_pkg::*;
;
	logic clk_sys, sys_rst, reg_wr, reg_rd, wr_is_i2c, conv_busy, conv_done, wr_nack, meas_press_en, deep_stby_off;
	logic nvm_read_unlock, nvm_prog_unlock, paging_on, page_sel, oor_event;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
	logic [16:0] press_sample;
	logic [1:0] pwr_mode_act;
	logic [2:0] osr_t_use, osr_p_use;
	logic [4:0] rate_sel;
	int bad_count = 0;
	int comparisons = 0;
	// Rows of address, write data, expected readback
	logic [23:0] rows [8] = '{24'h32A5A5, 24'h335A5A, 24'h34FFFF, 24'h35FFC1, 24'h36FF7F, 24'h7FFF90,
		24'h377373, 24'h377171};
	scfg_regs u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .wr_is_i2c(wr_is_i2c), .conv_busy(conv_busy), .conv_done(conv_done),
		.press_sample(press_sample), .reg_rdata(reg_rdata), .wr_nack(wr_nack), .pwr_mode_act(pwr_mode_act),
		.meas_press_en(meas_press_en), .osr_t_use(osr_t_use), .osr_p_use(osr_p_use), .rate_sel(rate_sel),
		.deep_stby_off(deep_stby_off), .nvm_read_unlock(nvm_read_unlock), .nvm_prog_unlock(nvm_prog_unlock),
		.paging_on(paging_on), .page_sel(page_sel), .oor_event(oor_event));
	scfg_host u_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .wr_is_i2c(wr_is_i2c));
	// ****************************************
	// Clock, verdict, watchdog
	// ****************************************
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic give_verdict;
		if (bad_count == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	// One finished conversion
	task automatic pulse_done;
		@(negedge clk_sys);
		conv_done = 1'b1;
		@(negedge clk_sys);
		conv_done = 1'b0;
	endtask : pulse_done
	initial begin
		#(25 * 5000);
		bad_count++;
		give_verdict();
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		sys_rst = 1'b1;
		conv_busy = 1'b0;
		conv_done = 1'b0;
		press_sample = 17'h00000;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		u_host.rd(ADDR_RATE_PWR, r);
		`CHK(r, RST_RATE_PWR)
		foreach (rows[i]) begin
			u_host.wr(rows[i][23:16], rows[i][15:8], 1'b0);
			u_host.rd(rows[i][23:16], r);
			`CHK(r, rows[i][7:0])
		end
		u_host.rd(ADDR_OSR_EFF, r);
		`CHK(r, 8'hBF)
		u_host.wr(ADDR_RATE_PWR, 8'h01, 1'b0);
		u_host.rd(ADDR_OSR_EFF, r);
		`CHK(r, 8'h00)
		`CHK({osr_t_use, osr_p_use}, 6'h00)
		u_host.wr(ADDR_RATE_PWR, 8'h72, 1'b0);
		u_host.rd(ADDR_RATE_PWR, r);
		`CHK(r, 8'h72)
		pulse_done();
		u_host.rd(ADDR_RATE_PWR, r);
		`CHK(r, 8'h70)
		u_host.wr(ADDR_CMD, CMD_UNLOCK_OPEN, 1'b0);
		u_host.rd(ADDR_CMD, r);
		`CHK(r, 8'h00)
		u_host.wr(ADDR_CMD, CMD_NVM_READ, 1'b0);
		`CHK(nvm_read_unlock, 1'b1)
		u_host.wr(ADDR_CMD, CMD_UNLOCK_OPEN, 1'b0);
		u_host.wr(ADDR_CMD, 8'h12, 1'b0);
		u_host.wr(ADDR_CMD, CMD_NVM_PROG, 1'b0);
		`CHK(nvm_prog_unlock, 1'b0)
		u_host.wr(ADDR_CMD, CMD_UNLOCK_OPEN, 1'b0);
		u_host.wr(ADDR_CMD, CMD_NVM_PROG, 1'b0);
		`CHK(nvm_prog_unlock, 1'b1)
		u_host.wr(ADDR_CMD, CMD_SOFT_RESET, 1'b1);
		`CHK({wr_nack, nvm_read_unlock}, 2'b10)
		u_host.rd(ADDR_OOR_THR_LOW, r);
		`CHK(r, RST_ZERO)
		// Writes during a conversion keep the locked fields
		conv_busy = 1'b1;
		u_host.wr(ADDR_OOR_CTRL, 8'h41, 1'b0);
		u_host.wr(ADDR_RATE_PWR, 8'hF0, 1'b0);
		conv_busy = 1'b0;
		u_host.rd(ADDR_OOR_CTRL, r);
		`CHK(r, 8'h01)
		u_host.rd(ADDR_RATE_PWR, r);
		`CHK(r, 8'h70)
		u_host.wr(ADDR_OOR_CTRL, 8'h00, 1'b0);
		u_host.wr(ADDR_OSR_SET, 8'h40, 1'b0);
		press_sample = 17'h00005;
		pulse_done();
		@(negedge clk_sys);
		`CHK(oor_event, 1'b1)
		u_host.rd(ADDR_INT_STAT, r);
		`CHK(r & 8'h08, 8'h08)
		u_host.rd(ADDR_INT_STAT, r);
		`CHK(r, 8'h00)
		give_verdict();
	end
endmodule : test_sensor_config_command_regs
`default_nettype wire
